/* File: design/spp_consts.svh */
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// ----------------------------------------
// clock and byte framing
// ----------------------------------------
`define SPP_CLK_MHZ 100
`define SPP_LAST_BIT 4'h7
`define SPP_EDGE_COUNT 5'h10

// ----------------------------------------
// sck half periods in system clocks, per rate choice
// ----------------------------------------
`define SPP_HALF_DIV2 7'h01
`define SPP_HALF_DIV4 7'h02
`define SPP_HALF_DIV8 7'h04
`define SPP_HALF_DIV16 7'h08
`define SPP_HALF_DIV32 7'h10
`define SPP_HALF_DIV64 7'h20
`define SPP_HALF_DIV128 7'h40

// ----------------------------------------
// reset values and receive buffer size
// ----------------------------------------
`define SPP_BYTE_RST 8'h00
`define SPP_SS_SYNC_RST 3'h7
`define SPP_FIFO_DEPTH 4
`define SPP_FIFO_WIDTH 8

`endif

/* File: design/spp_fifo.sv */
`timescale 1ns/1ps
module spp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   spp_stream_if.snk fill,
   spp_stream_if.src drain
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic in_ready;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } spp_fifo_state_type;
   spp_fifo_state_type q, d;
   logic push;
   logic pop;

   // output word sits in its own register, so the store holds DEPTH more
   always_comb begin
      d = q;
      push = fill.valid & q.in_ready;
      pop = drain.ready & q.out_valid;
      if (push) begin
         d.mem[q.wptr] = fill.data;
         d.wptr = q.wptr + 1'b1;
      end
      if ((!q.out_valid || pop) && (q.count != '0)) begin
         d.out_data = q.mem[q.rptr];
         d.out_valid = 1'b1;
         d.rptr = q.rptr + 1'b1;
      end else if (pop) begin
         d.out_valid = 1'b0;
      end
      if (push && !((!q.out_valid || pop) && (q.count != '0))) begin
         d.count = q.count + 1'b1;
      end else if (!push && ((!q.out_valid || pop) && (q.count != '0))) begin
         d.count = q.count - 1'b1;
      end
      d.in_ready = (d.count < (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign fill.ready = q.in_ready;
   assign drain.valid = q.out_valid;
   assign drain.data = q.out_data;
endmodule

/* File: design/spp_pkg.sv */
package spp_pkg;
   typedef logic [7:0] spp_byte_type;
   typedef logic [1:0] spp_rate_type;
   typedef enum logic [1:0] {
      SPP_IDLE,
      SPP_MASTER_RUN,
      SPP_SLAVE_RUN
   } spp_state_type;
endpackage

/* File: design/spp_stream_if.sv */
`timescale 1ns/1ps
interface spp_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: design/spp_top.sv */
`timescale 1ns/1ps
`include "spp_consts.svh"
// Functional notes
// - master write of a byte starts sck and shifts out eight bits.
// - after the master byte, sck stops and the done flag sets.
// - done flag set with interrupt enable raises the interrupt output.
// - last received byte is kept readable in the receive buffer.
// - slave with select high stays idle, miso not driven.
// - slave accepts writes while deselected; shifting waits for select low.
// - slave sets the done flag once a full byte shifted through.
// - slave may load the next byte before reading the received one.
// - transmit single buffered; writes only after the whole shift completes.
// - receive buffer holds five bytes; when full the master stalls and new slave bytes are lost.
// - enabled port overrides pin directions per master or slave mode.
// - data goes master to slave on mosi, back on miso, simultaneously.
// - port stays inactive unless the power gate bit is zero.
// - seven master sck rates including double speed system clock over two.
// - software picks lsb first or msb first shifting.
// - completed transfer interrupt can wake the system from idle.
// - slave select rising resets the shifter and drops partial bytes.
// - master with select input low drops to slave and sets done flag.
// - polarity sets sck idle level, phase picks leading or trailing sample.
module spp_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic port_power_gate,
   input wire logic port_enable,
   input wire logic master_set,
   input wire logic master_clear,
   input wire logic clock_polarity,
   input wire logic clock_phase,
   input wire logic data_order_lsb,
   input wire logic rate_double,
   input wire spp_pkg::spp_rate_type rate_sel,
   input wire logic ss_is_input,
   input wire logic dir_mosi,
   input wire logic dir_sck,
   input wire logic dir_miso,
   input wire logic transfer_irq_enable,
   input wire logic data_wr,
   input wire spp_pkg::spp_byte_type data_wr_byte,
   input wire logic done_clear,
   input wire logic wcol_clear,
   output logic rx_valid,
   output spp_pkg::spp_byte_type rx_data,
   input wire logic rx_ready,
   output logic transfer_done_flag,
   output logic write_collision,
   output logic transfer_irq,
   output logic master_select,
   output logic busy,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in
);
   import spp_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] sck_s;
      logic [2:0] mosi_s;
      logic [2:0] miso_s;
      logic [2:0] ss_s;
      logic sck_f;
      logic mosi_f;
      logic miso_f;
      logic ss_f;
      spp_state_type state;
      logic master;
      logic pending;
      spp_byte_type tx_buf;
      spp_byte_type tx_sh;
      spp_byte_type rx_sh;
      logic out;
      logic [6:0] div;
      logic sck;
      logic [4:0] edge_cnt;
      logic [3:0] smp;
      logic [3:0] bit_cnt;
      logic done_flag;
      logic wcol;
      logic irq;
      logic push;
      spp_byte_type push_data;
      logic sck_oe;
      logic mosi_oe;
      logic miso_oe;
   } spp_state_vec_type;

   spp_state_vec_type q, d;
   logic active;
   logic fifo_ready;
   logic [6:0] half;
   logic sck_lead;
   logic sck_trail;
   logic ss_fault;
   logic done_set;
   logic wr_block;

   spp_stream_if #(.WIDTH(`SPP_FIFO_WIDTH)) fill_if ();
   spp_stream_if #(.WIDTH(`SPP_FIFO_WIDTH)) drain_if ();

   // ----------------------------------------
   // bit order helpers
   // ----------------------------------------
   function automatic logic first_bit(input spp_byte_type b, input logic lsb);
      first_bit = lsb ? b[0] : b[7];
   endfunction

   function automatic spp_byte_type shift_out(input spp_byte_type b, input logic lsb);
      shift_out = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
   endfunction

   function automatic spp_byte_type shift_in(input spp_byte_type b, input logic bit_in,
                                             input logic lsb);
      shift_in = lsb ? {bit_in, b[7:1]} : {b[6:0], bit_in};
   endfunction

   // ----------------------------------------
   // rate select
   // ----------------------------------------
   always_comb begin
      case ({rate_double, rate_sel})
         3'h0: half = `SPP_HALF_DIV4;
         3'h1: half = `SPP_HALF_DIV16;
         3'h2: half = `SPP_HALF_DIV64;
         3'h3: half = `SPP_HALF_DIV128;
         3'h4: half = `SPP_HALF_DIV2;
         3'h5: half = `SPP_HALF_DIV8;
         3'h6: half = `SPP_HALF_DIV32;
         default: half = `SPP_HALF_DIV64;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      active = port_enable & ~port_power_gate;
      fifo_ready = fill_if.ready;
      done_set = 1'b0;
      d.push = 1'b0;
      d.smp = {q.smp[2:0], 1'b0};

      // three stage pin sync; a level counts once stages two and three agree
      d.sck_s = {q.sck_s[1:0], sck_in};
      d.mosi_s = {q.mosi_s[1:0], mosi_in};
      d.miso_s = {q.miso_s[1:0], miso_in};
      d.ss_s = {q.ss_s[1:0], ss_n_in};
      if (q.sck_s[1] == q.sck_s[2]) begin
         d.sck_f = q.sck_s[2];
      end
      if (q.mosi_s[1] == q.mosi_s[2]) begin
         d.mosi_f = q.mosi_s[2];
      end
      if (q.miso_s[1] == q.miso_s[2]) begin
         d.miso_f = q.miso_s[2];
      end
      if (q.ss_s[1] == q.ss_s[2]) begin
         d.ss_f = q.ss_s[2];
      end

      // leading edge leaves the idle level set by polarity
      sck_lead = clock_polarity ? (q.sck_f & ~d.sck_f) : (~q.sck_f & d.sck_f);
      sck_trail = clock_polarity ? (~q.sck_f & d.sck_f) : (q.sck_f & ~d.sck_f);

      // another master pulling select low while we lead the bus
      ss_fault = active & q.master & ss_is_input & ~q.ss_f;

      if (master_clear) begin
         d.master = 1'b0;
      end else if (master_set) begin
         d.master = 1'b1;
      end

      // single transmit buffer: a write is refused while a byte is in flight
      wr_block = (q.state != SPP_IDLE) | q.pending;
      if (active && data_wr) begin
         if (wr_block) begin
            d.wcol = 1'b1;
         end else if (q.master) begin
            d.tx_buf = data_wr_byte;
            d.pending = 1'b1;
         end else begin
            d.tx_buf = data_wr_byte;
         end
      end

      if (!active) begin
         d.state = SPP_IDLE;
         d.pending = 1'b0;
         d.sck = clock_polarity;
         d.bit_cnt = '0;
         d.edge_cnt = '0;
      end else if (ss_fault) begin
         d.master = 1'b0;
         done_set = 1'b1;
         d.state = SPP_IDLE;
         d.pending = 1'b0;
         d.sck = clock_polarity;
      end else if (q.master) begin
         // no select output here: software owns the select line
         case (q.state)
            SPP_IDLE: begin
               d.sck = clock_polarity;
               // a full receive buffer stalls the next master byte
               if (q.pending && fifo_ready && !q.push) begin
                  d.pending = 1'b0;
                  d.state = SPP_MASTER_RUN;
                  d.div = '0;
                  d.edge_cnt = '0;
                  d.bit_cnt = '0;
                  d.smp = '0;
                  if (!clock_phase) begin
                     d.out = first_bit(q.tx_buf, data_order_lsb);
                     d.tx_sh = shift_out(q.tx_buf, data_order_lsb);
                  end else begin
                     d.tx_sh = q.tx_buf;
                  end
               end
            end
            SPP_MASTER_RUN: begin
               // miso passes the pin sync, so each sample lands four clocks late
               if (q.smp[3]) begin
                  d.rx_sh = shift_in(q.rx_sh, q.miso_f, data_order_lsb);
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
               if (q.edge_cnt == `SPP_EDGE_COUNT) begin
                  // sck already parked; finish once the last late sample is in
                  if (q.smp == 4'h0) begin
                     d.state = SPP_IDLE;
                     done_set = 1'b1;
                     d.push = 1'b1;
                     d.push_data = q.rx_sh;
                  end
               end else if (q.div == half - 7'h01) begin
                  d.div = '0;
                  d.sck = ~q.sck;
                  d.edge_cnt = q.edge_cnt + 5'h01;
                  // phase 0 samples on the leading edge, phase 1 on the trailing
                  if ((q.edge_cnt[0] == 1'b0) == !clock_phase) begin
                     d.smp[0] = 1'b1;
                  end else begin
                     d.out = first_bit(q.tx_sh, data_order_lsb);
                     d.tx_sh = shift_out(q.tx_sh, data_order_lsb);
                  end
               end else begin
                  d.div = q.div + 7'h01;
               end
            end
            default: begin
               d.state = SPP_IDLE;
            end
         endcase
      end else if (q.ss_f) begin
         // deselected slave sleeps and forgets any partial byte
         d.state = SPP_IDLE;
         d.bit_cnt = '0;
         d.rx_sh = `SPP_BYTE_RST;
         d.sck = clock_polarity;
      end else begin
         d.sck = clock_polarity;
         if (q.state == SPP_IDLE) begin
            // before the first edge the shifter follows the data register
            if (!clock_phase) begin
               d.out = first_bit(q.tx_buf, data_order_lsb);
               d.tx_sh = shift_out(q.tx_buf, data_order_lsb);
            end else begin
               d.tx_sh = q.tx_buf;
            end
         end
         if ((q.state == SPP_IDLE && sck_lead) || q.state == SPP_SLAVE_RUN) begin
            if (q.state == SPP_IDLE) begin
               d.state = SPP_SLAVE_RUN;
               d.bit_cnt = '0;
            end
            if ((clock_phase ? sck_trail : sck_lead)) begin
               d.rx_sh = shift_in(q.rx_sh, q.mosi_f, data_order_lsb);
               d.bit_cnt = ((q.state == SPP_IDLE) ? 4'h0 : q.bit_cnt) + 4'h1;
               if (q.state == SPP_SLAVE_RUN && q.bit_cnt == `SPP_LAST_BIT) begin
                  d.state = SPP_IDLE;
                  done_set = 1'b1;
                  // slave cannot stall the master: a full buffer loses the byte
                  d.push = fifo_ready;
                  d.push_data = d.rx_sh;
               end
            end else if ((clock_phase ? sck_lead : sck_trail)) begin
               if (q.state == SPP_IDLE) begin
                  d.out = first_bit(q.tx_buf, data_order_lsb);
                  d.tx_sh = shift_out(q.tx_buf, data_order_lsb);
               end else begin
                  d.out = first_bit(q.tx_sh, data_order_lsb);
                  d.tx_sh = shift_out(q.tx_sh, data_order_lsb);
               end
            end
         end
      end

      // set wins over a clear in the same cycle
      if (done_set) begin
         d.done_flag = 1'b1;
      end else if (done_clear) begin
         d.done_flag = 1'b0;
      end
      if (active && data_wr && wr_block) begin
         d.wcol = 1'b1;
      end else if (wcol_clear) begin
         d.wcol = 1'b0;
      end

      // also the wake source out of idle sleep
      d.irq = d.done_flag & transfer_irq_enable;

      // pin direction override
      if (!active) begin
         d.sck_oe = 1'b0;
         d.mosi_oe = 1'b0;
         d.miso_oe = 1'b0;
      end else if (d.master) begin
         d.sck_oe = dir_sck;
         d.mosi_oe = dir_mosi;
         d.miso_oe = 1'b0;
      end else begin
         d.sck_oe = 1'b0;
         d.mosi_oe = 1'b0;
         d.miso_oe = dir_miso & ~d.ss_f;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0;
         q.ss_s <= `SPP_SS_SYNC_RST;
         q.ss_f <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // receive buffer
   // ----------------------------------------
   assign fill_if.valid = q.push;
   assign fill_if.data = q.push_data;
   assign drain_if.ready = rx_ready;

   spp_fifo #(
      .WIDTH(`SPP_FIFO_WIDTH),
      .DEPTH(`SPP_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .fill(fill_if),
      .drain(drain_if)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rx_valid = drain_if.valid;
   assign rx_data = drain_if.data;
   assign transfer_done_flag = q.done_flag;
   assign write_collision = q.wcol;
   assign transfer_irq = q.irq;
   assign master_select = q.master;
   assign busy = q.pending;
   assign sck_out = q.sck;
   assign sck_oe = q.sck_oe;
   assign mosi_out = q.out;
   assign mosi_oe = q.mosi_oe;
   assign miso_out = q.out;
   assign miso_oe = q.miso_oe;
endmodule

/* File: testbench/spp_checker.sv */
`timescale 1ns/1ps
module spp_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic port_power_gate,
   input wire logic port_enable,
   input wire logic clock_polarity,
   input wire logic ss_is_input,
   input wire logic ss_n_in,
   input wire logic transfer_irq_enable,
   input wire logic data_wr,
   input wire logic done_clear,
   input wire logic wcol_clear,
   input wire logic transfer_done_flag,
   input wire logic write_collision,
   input wire logic transfer_irq,
   input wire logic master_select,
   input wire logic busy,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe
);
   // ----------------------------------------
   // sck edges since the last start
   // ----------------------------------------
   logic [4:0] edge_q;
   logic [4:0] edge_d;
   logic sck_q;
   always_comb begin
      edge_d = busy ? 5'h00 : edge_q + {4'h0, sck_out != sck_q};
   end
   always_ff @(posedge clk_sys) begin
      sck_q <= sck_out;
      edge_q <= rst ? 5'h00 : edge_d;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // filtered select needs a few clocks, so the deselect must persist
   sequence s_deselected; (!master_select && ss_n_in) [*5]; endsequence
   sequence s_fault_low;
      (master_select && ss_is_input && !ss_n_in && port_enable && !port_power_gate) [*4];
   endsequence
   property p_irq; transfer_irq == (transfer_done_flag && $past(transfer_irq_enable)); endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_eight; $rose(transfer_done_flag) && master_select |-> edge_d == 5'h10; endproperty
   a_eight: assert property (p_eight) else $error("edge count");
   property p_stop;
      $rose(transfer_done_flag) && master_select |=> (sck_out == clock_polarity) [*2];
   endproperty
   a_stop: assert property (p_stop) else $error("sck not stopped");
   property p_write;
      data_wr && master_select && port_enable && !port_power_gate |=> busy || write_collision;
   endproperty
   a_write: assert property (p_write) else $error("write not taken");
   property p_wcol; write_collision && !wcol_clear |=> write_collision; endproperty
   a_wcol: assert property (p_wcol) else $error("collision lost");
   property p_done; transfer_done_flag && !done_clear |=> transfer_done_flag; endproperty
   a_done: assert property (p_done) else $error("done lost");
   property p_gate; port_power_gate [*2] |-> !sck_oe && !mosi_oe && !miso_oe; endproperty
   a_gate: assert property (p_gate) else $error("gated port drives");
   property p_slave_pins; (!master_select && port_enable) [*2] |-> !sck_oe && !mosi_oe; endproperty
   a_slave_pins: assert property (p_slave_pins) else $error("slave drives");
   property p_master_miso; master_select [*2] |-> !miso_oe; endproperty
   a_master_miso: assert property (p_master_miso) else $error("master drives miso");
   property p_slave_idle; s_deselected |-> !miso_oe; endproperty
   a_slave_idle: assert property (p_slave_idle) else $error("miso driven");
   property p_fault; s_fault_low |-> ##[0:2] (!master_select && transfer_done_flag); endproperty
   a_fault: assert property (p_fault) else $error("no mode fault");
endmodule
bind spp_top spp_checker spp_checker_i (.*);

/* File: testbench/spp_partner.sv */
`timescale 1ns/1ps
module spp_partner (
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic cpha,
   input wire logic lsb,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   int n_edge = 0;
   int k;
   logic held = 1'b0;
   always @(negedge ss_n) n_edge = 0;
   always @(posedge ss_n) held = miso;
   always @(sck) begin
      if (!ss_n) begin
         n_edge = n_edge + 1;
         if ((n_edge % 2 == 1) != cpha) begin
            rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
         end
      end
   end
   always_comb begin
      k = (n_edge - int'(cpha)) / 2;
      // a released line shows the inverse so a stale level cannot pass
      if (ss_n) miso = ~held;
      else miso = tx_byte[lsb ? k % 8 : 7 - k % 8];
   end
endmodule

/* File: testbench/spp_tb_top.sv */
`timescale 1ns/1ps
module spp_tb_top;
   import spp_pkg::*;
   typedef struct {
      logic [2:0] rate;
      logic cpol, cpha, lsb, ien;
      spp_byte_type mo, so;
      int half;
   } spp_row_type;
   logic clk_sys = 1'b0, rst = 1'b1, port_power_gate = 1'b0, port_enable = 1'b1;
   logic master_set = 1'b0, master_clear = 1'b0, clock_polarity = 1'b0, clock_phase = 1'b0;
   logic data_order_lsb = 1'b0, rate_double = 1'b0, ss_is_input = 1'b0;
   logic transfer_irq_enable = 1'b0, data_wr = 1'b0, done_clear = 1'b0, wcol_clear = 1'b0;
   logic rx_ready = 1'b0, ss_n_in = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0, sel_n = 1'b1;
   spp_rate_type rate_sel = 2'h0;
   spp_byte_type data_wr_byte = 8'h00, part_tx = 8'h00, rx_data, part_rx, got;
   logic rx_valid, transfer_done_flag, write_collision, transfer_irq, master_select, busy;
   logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, part_miso, sck_prev = 1'b0;
   wire logic sck_in = sck_oe ? sck_out : tb_sck;
   wire logic mosi_in = mosi_oe ? mosi_out : tb_mosi;
   wire logic miso_in = miso_oe ? miso_out : part_miso;
   int n_fail = 0, checked = 0, n_tog = 0, t_first = 0, t_last = 0, cyc = 0;
   spp_row_type rows [8] = '{
      '{3'h4, 0, 0, 0, 1, 8'hA5, 8'h3C, 1}, '{3'h0, 0, 1, 1, 0, 8'h01, 8'h80, 2},
      '{3'h5, 1, 0, 0, 1, 8'hC3, 8'h5A, 4}, '{3'h1, 1, 1, 1, 0, 8'h7E, 8'h81, 8},
      '{3'h6, 0, 0, 1, 1, 8'h12, 8'h34, 16}, '{3'h2, 0, 1, 0, 0, 8'hFE, 8'h01, 32},
      '{3'h7, 1, 0, 1, 1, 8'h96, 8'h69, 32}, '{3'h3, 1, 1, 0, 0, 8'h55, 8'hAA, 64}};
   spp_top spp_top_i (.*, .dir_mosi(1'b1), .dir_sck(1'b1), .dir_miso(1'b1));
   spp_partner spp_partner_i (.sck(sck_in), .ss_n(sel_n), .mosi(mosi_in), .cpha(clock_phase),
      .lsb(data_order_lsb), .tx_byte(part_tx), .miso(part_miso), .rx_byte(part_rx));
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (sck_out !== sck_prev) begin
         n_tog++;
         if (n_tog == 1) t_first = cyc;
         t_last = cyc;
      end
      sck_prev = sck_out;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask
   task automatic wait_hi(ref logic sig, input int lim);
      for (int i = 0; i < lim && sig !== 1'b1; i++) tick(1);
      if (sig !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: wait ran out", $time);
         tally_and_finish;
      end
   endtask
   task automatic wr(input spp_byte_type b);
      data_wr = 1'b1;
      data_wr_byte = b;
      tick(1);
      data_wr = 1'b0;
   endtask
   task automatic clr(input logic pop);
      done_clear = 1'b1;
      rx_ready = pop;
      tick(1);
      done_clear = 1'b0;
      rx_ready = 1'b0;
   endtask
   // slave side: sck phases of 8 clocks keep well above the filter delay
   task automatic slave_bits(input spp_byte_type b, input int n);
      for (int k = 0; k < n; k++) begin
         tb_mosi = b[7 - k];
         tick(8);
         got[7 - k] = miso_out;
         tb_sck = 1'b1;
         tick(8);
         tb_sck = 1'b0;
      end
      tick(8);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      tick(12);
      rst = 1'b0;
      tick(3);
      chk(transfer_done_flag, 0, "flag");
      chk(miso_oe, 0, "miso oe");
      $display("test reset done");
      master_set = 1'b1;
      tick(1);
      master_set = 1'b0;
      foreach (rows[i]) begin
         {rate_double, rate_sel} = rows[i].rate;
         clock_polarity = rows[i].cpol;
         clock_phase = rows[i].cpha;
         data_order_lsb = rows[i].lsb;
         transfer_irq_enable = rows[i].ien;
         part_tx = rows[i].so;
         tick(4);
         sel_n = 1'b0;
         n_tog = 0;
         tick(1);
         wr(rows[i].mo);
         wait_hi(transfer_done_flag, 20 * rows[i].half + 30);
         chk(n_tog, 16, "edges");
         chk(t_last - t_first, 15 * rows[i].half, "rate");
         chk(transfer_irq, rows[i].ien, "irq");
         tick(2);
         chk(sck_out, rows[i].cpol, "sck idle");
         chk(part_rx, rows[i].mo, "mosi byte");
         sel_n = 1'b1;
         wait_hi(rx_valid, 20);
         chk(rx_data, rows[i].so, "miso byte");
         clr(1'b1);
         $display("test row %0d done", i);
      end
      {rate_double, rate_sel} = 3'h4;
      sel_n = 1'b0;
      for (int j = 0; j < 6; j++) begin
         part_tx = 8'h10 + 8'(j);
         wr(8'h00);
         if (j < 5) wait_hi(transfer_done_flag, 60);
         if (j < 5) clr(1'b0);
      end
      tick(40);
      chk(busy, 1, "stall");
      for (int j = 0; j < 6; j++) begin
         wait_hi(rx_valid, 60);
         chk(rx_data, 8'h10 + 8'(j), "drain");
         clr(1'b1);
      end
      $display("test buffer done");
      part_tx = 8'h77;
      wr(8'h3C);
      tick(3);
      wr(8'hFF);
      tick(1);
      chk(write_collision, 1, "collision");
      wait_hi(transfer_done_flag, 60);
      chk(part_rx, 8'h3C, "kept byte");
      wait_hi(rx_valid, 20);
      clr(1'b1);
      wcol_clear = 1'b1;
      tick(1);
      wcol_clear = 1'b0;
      chk(write_collision, 0, "wcol clear");
      port_power_gate = 1'b1;
      tick(2);
      wr(8'h11);
      tick(2);
      chk(busy, 0, "gated write");
      port_power_gate = 1'b0;
      ss_is_input = 1'b1;
      ss_n_in = 1'b0;
      tick(8);
      chk(master_select, 0, "fault mode");
      chk(transfer_done_flag, 1, "fault flag");
      ss_n_in = 1'b1;
      ss_is_input = 1'b0;
      clr(1'b0);
      sel_n = 1'b1;
      {clock_polarity, clock_phase, data_order_lsb} = 3'h0;
      tick(6);
      chk(miso_oe, 0, "deselected");
      ss_n_in = 1'b0;
      tick(8);
      chk(miso_oe, 1, "slave miso");
      slave_bits(8'hFF, 3);
      ss_n_in = 1'b1;
      tick(8);
      wr(8'hC5);
      slave_bits(8'hFF, 2);
      chk(transfer_done_flag, 0, "partial");
      ss_n_in = 1'b0;
      tick(8);
      slave_bits(8'h3A, 8);
      chk(transfer_done_flag, 1, "slave done");
      chk(got, 8'hC5, "slave miso");
      wait_hi(rx_valid, 40);
      chk(rx_data, 8'h3A, "slave rx");
      $display("test slave done");
      tally_and_finish;
   end
endmodule
